// [design/codec_port_frame_slot_control.sv]
// Purpose: codec port secondary-communication data path and slot control
// Assumes: register port with read data one cycle after the read strobe
// Notes: mode and codec select arrive as plain inputs
//
// Operation
// R01: low data register holds bits 7:0 of the command/status value.
// R02: high data register holds bits 15:8 of the command/status value.
// R03: software loads command data; device transmits it to the chosen codec.
// R04: codec read overwrites the data registers with returned status data.
// R05: general and serial codec modes carry only the low data byte.
// R06: high data register ignored in general and serial codec modes.
// R07: low valid-slot bits 7 to 3 flag slots 8 to 12.
// R08: high valid-slot bits 4 to 0 flag slots 3 to 7.
// R09: software sets flags of valid slots and clears the others.
// R10: software sets frame-valid bit 7; device sends it with the frame.
// R11: primary ready follows bit 15 of incoming primary slot 0 each frame.
// R12: secondary ready follows bit 15 of incoming secondary slot 0 each frame.
// R13: valid-slot registers used only in AC 97 modes, ignored otherwise.
// R14: low valid-slot bits 2 to 0 are reserved and read zero.
// R15: software sets address bit 7 for read, clears it for write.
// R16: codec read replaces the address field with the returned address; the code does this in AC 97 modes only.
// R17: codec select 00 picks primary codec, any other value secondary.
// R18: frame-valid and slot 3 to 12 flags go into the outgoing tag.
// R19: after reset all registers of the block read zero.
`timescale 1ns/10ps
`default_nettype none
`include "codec_port_defines.svh"

module codec_port_frame_slot_control
  import codec_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire link_mode_t mode,
  input wire logic [1:0] codec_select_field,
  input wire logic sdi_primary,
  input wire logic sdi_secondary,
  output logic link_sync,
  output logic link_sdo,
  output logic txn_busy
);

  // ****************************************
  // declarations
  // ****************************************
  logic frame_valid_bit_q;
  logic [9:0] slot_valid_flag_q;
  logic primary_ready_flag_q;
  logic secondary_ready_flag_q;
  logic [7:0] data_high_q;
  logic [7:0] data_low_q;
  logic [7:0] codec_address_q;
  txn_state_t txn_q;
  logic [1:0] wait_frames_q;
  logic [2:0] div_q;
  logic bit_en_q;
  logic ac97;
  logic secondary_sel;
  logic [15:0] tag_word;
  logic [19:0] addr_word;
  logic [19:0] data_word;
  logic [15:0] cmd_value;
  logic cmd_req;
  logic read_back;
  logic eng_sync;
  logic eng_sdo;
  logic frame_tick;
  logic cmd_taken;
  logic prim_ready;
  logic sec_ready;
  logic resp_valid;
  logic [6:0] resp_addr;
  logic [15:0] resp_data;
  logic [7:0] read_value;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic is_ac97(input link_mode_t m);
    return m == MODE_AC97 || m == MODE_AC97_DUAL;
  endfunction

  // ****************************************
  // mode decode
  // ****************************************
  assign ac97 = is_ac97(mode);
  assign secondary_sel = codec_select_field != 2'b00; // R17
  assign cmd_req = txn_q == TXN_SEND;
  // a response only counts while a read is outstanding
  assign read_back = resp_valid && txn_q == TXN_WAIT;

  // 8-bit modes send the low byte where replies return it, high byte dropped
  assign cmd_value = ac97 ? {data_high_q, data_low_q} // R01 R02
                          : {data_low_q, 8'h00}; // R05 R06

  // slot 0 tag, empty outside AC 97 modes except the slot 1 and 2 flags the engine adds
  always_comb begin
    tag_word = 16'h0000;
    if (ac97) begin // R13
      tag_word[`TAG_FRAME_VALID] = frame_valid_bit_q; // R10 R18
      tag_word[12:3] = slot_valid_flag_q; // R18
      tag_word[1:0] = codec_select_field; // R17
    end
  end

  assign addr_word = {codec_address_q, 12'h000};
  assign data_word = {cmd_value, 4'h0}; // R03

  // ****************************************
  // bit rate divider
  // ****************************************
  // divided rate stands in for the link bit clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 3'h0;
      bit_en_q <= 1'b0;
    end else begin
      bit_en_q <= div_q == 3'((`BIT_DIV) - 1);
      if (div_q == 3'((`BIT_DIV) - 1)) begin
        div_q <= 3'h0;
      end else begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  // ****************************************
  // frame engine
  // ****************************************
  codec_frame_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .bit_en(bit_en_q),
    .tag_word(tag_word),
    .addr_word(addr_word),
    .data_word(data_word),
    .cmd_req(cmd_req),
    .sdi_primary(sdi_primary),
    .sdi_secondary(sdi_secondary),
    .use_secondary(secondary_sel),
    .frame_sync(eng_sync),
    .sdo(eng_sdo),
    .frame_tick(frame_tick),
    .cmd_taken(cmd_taken),
    .prim_ready(prim_ready),
    .sec_ready(sec_ready),
    .resp_valid(resp_valid),
    .resp_addr(resp_addr),
    .resp_data(resp_data)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_sync <= 1'b0;
      link_sdo <= 1'b0;
    end else begin
      link_sync <= eng_sync;
      link_sdo <= eng_sdo; // R03
    end
  end

  // ****************************************
  // transaction sequencing
  // ****************************************
  // writing the address register launches a transaction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txn_q <= TXN_IDLE;
      wait_frames_q <= 2'h0;
    end else begin
      unique case (txn_q)
        TXN_IDLE: begin
          if (wr && hit(addr, `OFS_CODEC_ADDRESS)) begin
            txn_q <= TXN_SEND; // R03
          end
        end
        TXN_SEND: begin
          if (cmd_taken) begin
            wait_frames_q <= 2'h0;
            // R15: bit 7 set means the codec answers with status
            txn_q <= codec_address_q[`ADDR_RW_BIT] ? TXN_WAIT : TXN_IDLE;
          end
        end
        TXN_WAIT: begin
          // a silent codec must not hang the port forever
          if (read_back) begin
            txn_q <= TXN_IDLE;
          end else if (frame_tick) begin
            if (wait_frames_q == `RESP_FRAMES) begin
              txn_q <= TXN_IDLE;
            end else begin
              wait_frames_q <= wait_frames_q + 2'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txn_busy <= 1'b0;
    end else begin
      txn_busy <= txn_q != TXN_IDLE;
    end
  end

  // ****************************************
  // command and status data
  // ****************************************
  // returned status beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_low_q <= `REG_RESET; // R19
    end else if (read_back) begin
      data_low_q <= ac97 ? resp_data[7:0] : resp_data[15:8]; // R04 R05
    end else if (wr && hit(addr, `OFS_CMD_DATA_LOW)) begin
      data_low_q <= wdata; // R01
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_high_q <= `REG_RESET; // R19
    end else if (read_back && ac97) begin
      data_high_q <= resp_data[15:8]; // R04 R06
    end else if (wr && hit(addr, `OFS_CMD_DATA_HIGH)) begin
      data_high_q <= wdata; // R02
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      codec_address_q <= `REG_RESET; // R19
    end else if (read_back && ac97) begin
      codec_address_q[6:0] <= resp_addr; // R16
    end else if (wr && hit(addr, `OFS_CODEC_ADDRESS)) begin
      codec_address_q <= wdata; // R15
    end
  end

  // ****************************************
  // valid slots and ready flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_valid_bit_q <= 1'b0; // R19
      slot_valid_flag_q <= 10'h000;
    end else if (wr) begin
      if (hit(addr, `OFS_SLOT_VALID_HIGH)) begin
        frame_valid_bit_q <= wdata[`VH_FRAME_VALID]; // R10
        slot_valid_flag_q[9:5] <= wdata[4:0]; // R08 R09
      end
      if (hit(addr, `OFS_SLOT_VALID_LOW)) begin
        slot_valid_flag_q[4:0] <= wdata[7:3]; // R07 R09
      end
    end
  end

  // refreshed once a frame from the received slot 0 tags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      primary_ready_flag_q <= 1'b0; // R19
      secondary_ready_flag_q <= 1'b0;
    end else if (frame_tick) begin
      primary_ready_flag_q <= prim_ready; // R11
      secondary_ready_flag_q <= sec_ready; // R12
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    read_value = 8'h00;
    if (hit(addr, `OFS_SLOT_VALID_HIGH)) begin
      read_value[`VH_FRAME_VALID] = frame_valid_bit_q;
      read_value[`VH_PRIMARY_READY] = primary_ready_flag_q; // R11
      read_value[`VH_SECONDARY_READY] = secondary_ready_flag_q; // R12
      read_value[4:0] = slot_valid_flag_q[9:5]; // R08
    end else if (hit(addr, `OFS_SLOT_VALID_LOW)) begin
      read_value = {slot_valid_flag_q[4:0], 3'b000}; // R07 R14
    end else if (hit(addr, `OFS_CMD_DATA_HIGH)) begin
      read_value = data_high_q;
    end else if (hit(addr, `OFS_CMD_DATA_LOW)) begin
      read_value = data_low_q;
    end else if (hit(addr, `OFS_CODEC_ADDRESS)) begin
      read_value = codec_address_q;
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? read_value : 8'h00;
    end
  end

endmodule
`default_nettype wire

// [design/codec_port_defines.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 50 MHz clock
// Notes: included by the codec port design files
`ifndef CODEC_PORT_DEFINES_SVH
`define CODEC_PORT_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_SLOT_VALID_HIGH 16'hffd7
`define OFS_SLOT_VALID_LOW 16'hffd8
`define OFS_CMD_DATA_HIGH 16'hffd9
`define OFS_CMD_DATA_LOW 16'hffda
`define OFS_CODEC_ADDRESS 16'hffdb

// ****************************************
// field positions and reset values
// ****************************************
`define VH_FRAME_VALID 7
`define VH_PRIMARY_READY 6
`define VH_SECONDARY_READY 5
`define ADDR_RW_BIT 7
`define REG_RESET 8'h00
`define TAG_FRAME_VALID 15
`define TAG_SLOT1_VALID 14
`define TAG_SLOT2_VALID 13
`define CODEC_READY_BIT 15

// ****************************************
// frame shape and timing
// ****************************************
`define SLOT0_MSB 5'h0f
`define SLOT_MSB 5'h13
`define LAST_SLOT 4'hc
`define CLK_HZ 50000000
`define BIT_HZ 12500000
`define BIT_DIV (`CLK_HZ / `BIT_HZ)
`define RESP_FRAMES 2'h2

`endif

// [design/codec_port_pkg.sv]
// Purpose: shared types of the codec port frame and slot control
// Assumes: nothing beyond the defines header
// Notes: offsets and counts live in the defines header
package codec_port_pkg;

  typedef enum logic [1:0] {
    MODE_AC97,
    MODE_AC97_DUAL,
    MODE_GENERAL,
    MODE_SERIAL_CODEC
  } link_mode_t;

  typedef enum logic [1:0] {
    TXN_IDLE,
    TXN_SEND,
    TXN_WAIT
  } txn_state_t;

endpackage

// [design/codec_frame_engine.sv]
// Purpose: frame counter, slot serializer and slot 0..2 receiver
// Assumes: bit_en is a one-cycle pulse per link bit
// Notes: words are latched at frame start so a frame is consistent
`timescale 1ns/10ps
`default_nettype none
`include "codec_port_defines.svh"

module codec_frame_engine (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_en,
  input wire logic [15:0] tag_word,
  input wire logic [19:0] addr_word,
  input wire logic [19:0] data_word,
  input wire logic cmd_req,
  input wire logic sdi_primary,
  input wire logic sdi_secondary,
  input wire logic use_secondary,
  output logic frame_sync,
  output logic sdo,
  output logic frame_tick,
  output logic cmd_taken,
  output logic prim_ready,
  output logic sec_ready,
  output logic resp_valid,
  output logic [6:0] resp_addr,
  output logic [15:0] resp_data
);

  logic [3:0] slot_q;
  logic [4:0] bit_q;
  logic [15:0] tag_q;
  logic [19:0] addr_q;
  logic [19:0] data_q;
  logic [18:0] rx_q;
  logic rx_slot1_q;
  logic start;
  logic sdi_sel;
  logic [19:0] rx_word;

  function automatic logic pick_bit(input logic [3:0] s, input logic [4:0] b,
                                    input logic [15:0] t, input logic [19:0] a,
                                    input logic [19:0] d);
    logic r;
    r = 1'b0;
    if (s == 4'h0) begin
      r = t[b[3:0]];
    end else if (s == 4'h1) begin
      r = a[b];
    end else if (s == 4'h2) begin
      r = d[b];
    end
    return r;
  endfunction

  assign start = bit_en && slot_q == 4'h0 && bit_q == `SLOT0_MSB;
  assign sdi_sel = use_secondary ? sdi_secondary : sdi_primary;
  assign rx_word = {rx_q, sdi_sel};

  // ****************************************
  // frame position
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_q <= 4'h0;
      bit_q <= `SLOT0_MSB;
    end else if (bit_en) begin
      if (bit_q != 5'h00) begin
        bit_q <= bit_q - 5'h01;
      end else if (slot_q == `LAST_SLOT) begin
        slot_q <= 4'h0;
        bit_q <= `SLOT0_MSB;
      end else begin
        slot_q <= slot_q + 4'h1;
        bit_q <= `SLOT_MSB;
      end
    end
  end

  // ****************************************
  // outgoing frame
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tag_q <= 16'h0000;
      addr_q <= 20'h0_0000;
      data_q <= 20'h0_0000;
      frame_sync <= 1'b0;
      sdo <= 1'b0;
      frame_tick <= 1'b0;
      cmd_taken <= 1'b0;
    end else begin
      frame_tick <= start;
      cmd_taken <= start & cmd_req;
      if (start) begin
        tag_q <= tag_word;
        tag_q[`TAG_SLOT1_VALID] <= cmd_req;
        tag_q[`TAG_SLOT2_VALID] <= cmd_req & ~addr_word[19];
        addr_q <= addr_word;
        data_q <= data_word;
        frame_sync <= 1'b1;
        sdo <= tag_word[`TAG_FRAME_VALID];
      end else if (bit_en) begin
        frame_sync <= slot_q == 4'h0;
        sdo <= pick_bit(slot_q, bit_q, tag_q, addr_q, data_q);
      end
    end
  end

  // ****************************************
  // incoming slots 0..2
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_q <= 19'h0_0000;
      rx_slot1_q <= 1'b0;
      prim_ready <= 1'b0;
      sec_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_addr <= 7'h00;
      resp_data <= 16'h0000;
    end else begin
      resp_valid <= 1'b0;
      if (bit_en) begin
        rx_q <= rx_word[18:0];
        if (slot_q == 4'h0 && bit_q == `SLOT0_MSB) begin
          prim_ready <= sdi_primary;
          sec_ready <= sdi_secondary;
        end
        if (slot_q == 4'h0 && bit_q == 5'h0e) begin
          rx_slot1_q <= sdi_sel;
        end
        if (slot_q == 4'h1 && bit_q == 5'h00) begin
          resp_addr <= rx_word[18:12];
        end
        if (slot_q == 4'h2 && bit_q == 5'h00) begin
          resp_data <= rx_word[19:4];
          resp_valid <= rx_slot1_q;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [testbench/codec_port_frame_slot_control_props.sv]
// Purpose: port checker for the codec frame slot control
// Assumes: slot 0 spans 16 link bits of 4 clocks each
// Notes: shadows only the frame valid bit, not the whole map
`timescale 1ns/10ps
`default_nettype none
module codec_port_props
  import codec_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire link_mode_t mode,
  input wire logic link_sync,
  input wire logic link_sdo,
  input wire logic txn_busy
);
  logic [6:0] sync_cnt_q;
  logic [12:0] busy_cnt_q;
  logic vf_q;
  // ****
  // helpers
  // ****
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_cnt_q <= 7'h00;
      busy_cnt_q <= 13'h0000;
      vf_q <= 1'b0;
    end else begin
      sync_cnt_q <= link_sync ? sync_cnt_q + 7'h01 : 7'h00;
      busy_cnt_q <= txn_busy ? busy_cnt_q + 13'h0001 : 13'h0000;
      if (wr && addr == 16'hffd7) vf_q <= wdata[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // assertions
  // ****
  reset_quiet_a: assert property ($rose(rst_n) |-> rdata == 8'h00 && !txn_busy && !link_sync)
    else $error("outputs not quiet after reset");
  low_reserved_a: assert property ($past(rd) && $past(addr) == 16'hffd8 |-> rdata[2:0] == 3'h0)
    else $error("reserved slot bits not zero");
  sync_width_a: assert property ($fell(link_sync) |-> sync_cnt_q == 7'h40)
    else $error("slot 0 sync not 64 clocks");
  bit_hold_a: assert property ($changed(link_sdo) |=> $stable(link_sdo) [*3])
    else $error("link bit shorter than 4 clocks");
  frame_valid_a: assert property ($rose(link_sync)
    && mode inside {MODE_AC97, MODE_AC97_DUAL} && $past(mode, 8) == mode
    && $past(vf_q, 8) == vf_q |-> link_sdo == vf_q)
    else $error("tag bit 15 differs from frame valid");
  idle_tag_a: assert property ($rose(link_sync)
    && mode inside {MODE_GENERAL, MODE_SERIAL_CODEC} && $past(mode, 8) == mode |-> !link_sdo)
    else $error("tag sent outside link modes");
  busy_bound_a: assert property (txn_busy |-> busy_cnt_q < 13'h1400)
    else $error("transaction never ends");
  low_data_a: assert property (!txn_busy && wr && addr == 16'hffda ##1 !txn_busy && rd
    && addr == 16'hffda |=> rdata == $past(wdata, 2))
    else $error("low data byte not kept");
  low_slots_a: assert property (!txn_busy && wr && addr == 16'hffd8 ##1 rd
    && addr == 16'hffd8 |=> rdata == ($past(wdata, 2) & 8'hf8))
    else $error("low slot flags not kept");
  high_slots_a: assert property (wr && addr == 16'hffd7 ##1 rd && addr == 16'hffd7
    |=> {rdata[7], rdata[4:0]} == {$past(wdata[7], 2), $past(wdata[4:0], 2)})
    else $error("high slot flags not kept");
endmodule
bind codec_port_frame_slot_control codec_port_props props_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .mode(mode), .link_sync(link_sync), .link_sdo(link_sdo), .txn_busy(txn_busy)
);
`default_nettype wire

// [testbench/codec_link_model.sv]
// Purpose: behavioural codec on the far side of the link
// Assumes: bit edges follow the rise of link_sync
// Notes: unused slots carry a toggling pattern, not a kind zero
`timescale 1ns/10ps
`default_nettype none
module codec_link_model #(
  parameter bit IS_PRIMARY = 1'b1,
  parameter logic [6:0] REPLY_ADDR = 7'h00,
  parameter logic [15:0] REPLY_DATA = 16'h0000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_sync,
  input wire logic link_sdo,
  input wire logic ready,
  input wire logic slow,
  output logic sdi,
  output logic [55:0] rx_frame,
  output logic [15:0] frame_count
);
  logic sync_q;
  logic [1:0] ph_q;
  logic [8:0] bit_q;
  logic [55:0] sh_q;
  logic [55:0] tx;
  logic rep_q;
  logic rep2_q;
  logic send;
  logic me;
  // ****
  // outgoing slots 0 to 2
  // ****
  assign me = IS_PRIMARY ? (sh_q[41:40] == 2'h0) : (sh_q[41:40] != 2'h0);
  assign send = slow ? rep2_q : rep_q;
  assign tx = {ready, send, send, 13'h0000, 1'b0, REPLY_ADDR, 12'h000, REPLY_DATA, 4'h0};
  // each bit leads by one bit time: the host samples a position as it launches it
  assign sdi = (bit_q == 9'h0ff) ? tx[55] : (bit_q < 9'h037) ? tx[9'h036 - bit_q] : ph_q[0];
  // ****
  // frame tracking and capture
  // ****
  always_ff @(posedge clk) begin
    sync_q <= link_sync;
    if (!rst_n) begin
      ph_q <= 2'h0;
      bit_q <= 9'h1ff;
      rep_q <= 1'b0;
      rep2_q <= 1'b0;
      frame_count <= 16'h0000;
    end else if (link_sync && !sync_q) begin
      ph_q <= 2'h1;
      bit_q <= 9'h000;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h3 && bit_q != 9'h1ff) bit_q <= bit_q + 9'h001;
      if (ph_q == 2'h2 && bit_q < 9'h038) sh_q <= {sh_q[54:0], link_sdo};
      if (ph_q == 2'h2 && bit_q == 9'h038) begin
        rx_frame <= sh_q;
        frame_count <= frame_count + 16'h0001;
        rep_q <= sh_q[54] && sh_q[39] && me;
        rep2_q <= rep_q;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_codec_port_frame_slot_control.sv]
// Purpose: self-checking bench for the codec frame slot control
// Assumes: frames of 1024 clocks, two codec models on the link
// Notes: secondary codec answers one frame late
`timescale 1ns/10ps
`default_nettype none
module tb_codec_port_frame_slot_control
  import codec_port_pkg::*;
;
  logic clk;
  logic rst_n, wr, rd, p_ready, s_ready, s_slow;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  link_mode_t mode;
  logic [1:0] sel;
  logic sdi_p, sdi_s, link_sync, link_sdo, txn_busy;
  logic [55:0] fr_p;
  logic [15:0] cnt_p;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  codec_port_frame_slot_control DUT (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mode(mode), .codec_select_field(sel), .sdi_primary(sdi_p), .sdi_secondary(sdi_s),
    .link_sync(link_sync), .link_sdo(link_sdo), .txn_busy(txn_busy));
  codec_link_model #(.REPLY_ADDR(7'h11), .REPLY_DATA(16'h5a5a)) prim (
    .clk(clk), .rst_n(rst_n), .link_sync(link_sync), .link_sdo(link_sdo), .ready(p_ready),
    .slow(s_slow), .sdi(sdi_p), .rx_frame(fr_p), .frame_count(cnt_p));
  codec_link_model #(.IS_PRIMARY(1'b0), .REPLY_ADDR(7'h33), .REPLY_DATA(16'hbeef)) scnd (
    .clk(clk), .rst_n(rst_n), .link_sync(link_sync), .link_sdo(link_sdo), .ready(s_ready),
    .slow(s_slow), .sdi(sdi_s), .rx_frame(), .frame_count());
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****
  // shared tasks
  // ****
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // wr stays up until the next access lowers it, so writes can run back to back
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
  endtask
  task automatic expect_reg(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, {12'h000, rdata}, {12'h000, exp});
  endtask
  task automatic wait_frames(input int n);
    logic [15:0] start;
    @(posedge clk);
    wr <= 1'b0;
    start = cnt_p;
    for (int i = 0; i < n * 1100 && cnt_p != start + 16'(n); i++) @(posedge clk);
  endtask
  // two edges first, so the launching write has landed
  task automatic wait_idle();
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 6000 && txn_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    check("busy", {19'h0_0000, txn_busy}, 20'h0_0000);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    logic [15:0] a [5] = '{16'hffd7, 16'hffd8, 16'hffd9, 16'hffda, 16'hffd6};
    logic [7:0] e [5] = '{8'h9f, 8'hf8, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 5; i++) expect_reg("reset value", a[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      wreg(a[i], 8'hff);
      expect_reg("readback", a[i], e[i]);
    end
    $display("register test done");
  endtask
  task automatic t_ac97_write();
    wreg(16'hffd7, 8'h95);
    wreg(16'hffd8, 8'ha8);
    wreg(16'hffd9, 8'h12);
    wreg(16'hffda, 8'h34);
    wreg(16'hffdb, 8'h2a);
    wait_idle();
    wait_frames(1);
    check("tag", {4'h0, fr_p[55:40]}, {4'h0, 3'h7, 5'h15, 5'h15, 3'h0});
    check("slot1", fr_p[39:20], 20'h2_a000);
    check("slot2", fr_p[19:0], 20'h1_2340);
    $display("link write test done");
  endtask
  task automatic t_ac97_read();
    @(posedge clk);
    mode <= MODE_AC97_DUAL;
    wreg(16'hffdb, 8'h85);
    wait_idle();
    expect_reg("primary address", 16'hffdb, 8'h91);
    expect_reg("primary data", 16'hffda, 8'h5a);
    @(posedge clk);
    sel <= 2'h1;
    s_slow <= 1'b1;
    wreg(16'hffdb, 8'h85);
    wait_idle();
    expect_reg("address", 16'hffdb, 8'hb3);
    expect_reg("data high", 16'hffd9, 8'hbe);
    expect_reg("data low", 16'hffda, 8'hef);
    $display("link read test done");
  endtask
  task automatic t_other_modes();
    link_mode_t m [2] = '{MODE_GENERAL, MODE_SERIAL_CODEC};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      mode <= m[i];
      wreg(16'hffd9, 8'hc3);
      wreg(16'hffda, 8'h3c);
      wreg(16'hffdb, 8'h07);
      wait_idle();
      wait_frames(1);
      check("idle tag", {4'h0, fr_p[55:40]}, 20'h0_6000);
      check("byte slot", fr_p[19:0], 20'h3_c000);
    end
    $display("other mode test done");
  endtask
  task automatic t_ready();
    @(posedge clk);
    mode <= MODE_AC97_DUAL;
    p_ready <= 1'b1;
    wait_frames(3);
    expect_reg("primary ready", 16'hffd7, 8'hd5);
    @(posedge clk);
    p_ready <= 1'b0;
    s_ready <= 1'b1;
    wait_frames(3);
    wreg(16'hffd7, 8'h40);
    expect_reg("secondary ready", 16'hffd7, 8'h20);
    $display("ready test done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    mode = MODE_AC97;
    sel = 2'h0;
    p_ready = 1'b0;
    s_ready = 1'b0;
    s_slow = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_ac97_write();
    t_ac97_read();
    t_other_modes();
    t_ready();
    finish_test();
  end
endmodule
`default_nettype wire
